// ---- design/afe_cfg_reg.sv ----
// One read/write configuration register, reset to zero.
// Assumes write strobe and data come from logic on core_clk.
module afe_cfg_reg
  import afe_pkg::*;
#(
  parameter int unsigned W = AFE_DATA_W
)
(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         wr_stb,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] q
);

  logic [W-1:0] val_ff;
  logic [W-1:0] nxt_val;

  always_comb
  begin
    nxt_val = val_ff;
    if (wr_stb)
    begin
      nxt_val = wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      val_ff <= W'(AFE_REG_RESET);
    end
    else
    begin
      val_ff <= nxt_val;
    end
  end

  assign q = val_ff;

endmodule

// ---- design/afe_cfg_regs.sv ----
// Front-end configuration bank: range, common mode, power-down and init registers.
// Assumes a serial configuration decoder on core_clk presents one access per strobe.
// Decoded fields are registered, so they follow a write by two clock edges.

// Behaviour
// - Channel B range code in bits 7..4 selects span 5,3.5,2.5,7,10,12 V.
// - Common-mode fields code 0 half span, 1 six volts, 2 twelve volts.
// - Per-channel enable bit off disables wide common-mode control, on enables it.
// - Power-down bit set sleeps the whole chip; clear keeps normal operation.
// - Override bit clear forces twelve volt common mode on both channels.
// - Every register here resets to zero in all fields.
module afe_cfg_regs
  import afe_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire afe_req_s              req,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic     [AFE_DATA_W-1:0]  rd_data_ff,
  output logic                       rd_ack_ff,
  output logic                       unmapped_ff,
  output afe_cfg_s                   cfg_ff,
  output afe_init_s                  init_ff
);

  logic [AFE_REG_COUNT-1:0] hit;
  logic [AFE_REG_COUNT-1:0] reg_wr;
  logic [AFE_DATA_W-1:0]    reg_q [AFE_REG_COUNT];
  logic [AFE_DATA_W-1:0]    nxt_rd_data;
  logic                     nxt_rd_ack;
  logic                     nxt_unmapped;
  afe_cfg_s                 nxt_cfg;
  afe_init_s                nxt_init;
  logic [3:0]               range_b;
  logic [6:0]               span_b;
  logic                     span_b_ok;
  logic [1:0]               span_code [2];
  logic                     ctrl_on [2];
  afe_cm_e                  cm_mode [2];
  logic                     override_on;

  // Address decode, bank qualifies offset
  always_comb
  begin
    for (int i = 0; i < AFE_REG_COUNT; i++)
    begin
      hit[i] = (req.bank == AFE_REG_BANK[i]) && (req.addr == AFE_REG_OFS[i]);
    end
  end

  // Write enables
  assign reg_wr = hit & {AFE_REG_COUNT{wr_stb}};

  // Register storage, all bits writable
  for (genvar g = 0; g < AFE_REG_COUNT; g++)
  begin : g_reg
    afe_cfg_reg #(
      .W (AFE_DATA_W)
    ) u_reg (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_stb   (reg_wr[g]),
      .wr_data  (req.data),
      .q        (reg_q[g])
    );
  end

  // Read path and unmapped access flag
  always_comb
  begin
    nxt_rd_data  = AFE_RD_NONE;
    nxt_rd_ack   = rd_stb;
    nxt_unmapped = (rd_stb || wr_stb) && (hit == '0);
    if (rd_stb)
    begin
      for (int i = 0; i < AFE_REG_COUNT; i++)
      begin
        if (hit[i])
        begin
          nxt_rd_data = reg_q[i];
        end
      end
    end
  end

  // Read answer registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_ff  <= AFE_RD_NONE;
      rd_ack_ff   <= 1'b0;
      unmapped_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff  <= nxt_rd_data;
      rd_ack_ff   <= nxt_rd_ack;
      unmapped_ff <= nxt_unmapped;
    end
  end

  // Field extraction
  assign range_b     = reg_q[IDX_CHAN_B_RANGE][POS_CHAN_B_RANGE_LO +: 4];
  assign span_code[1] = reg_q[IDX_CM_AND_PD][POS_CHAN_B_CM_SPAN_LO +: 2];
  assign span_code[0] = reg_q[IDX_CM_AND_PD][POS_CHAN_A_CM_SPAN_LO +: 2];
  assign ctrl_on[1]   = reg_q[IDX_CM_AND_PD][POS_CHAN_B_CM_CTRL_ON];
  assign ctrl_on[0]   = reg_q[IDX_CM_AND_PD][POS_CHAN_A_CM_CTRL_ON];
  assign override_on = reg_q[IDX_CM_OVERRIDE][POS_CM_GLOBAL_OVERRIDE];

  // Common-mode pick, index 0 is channel A and index 1 channel B
  // A clear override bit wins over both per-channel fields
  for (genvar c = 0; c < 2; c++)
  begin : g_cm
    afe_cm_e mode;
    always_comb
    begin
      mode = AFE_CM_HALF_SPAN;
      if (!override_on)
      begin
        mode = AFE_CM_12V;
      end
      else if (!ctrl_on[c])
      begin
        mode = AFE_CM_HALF_SPAN;
      end
      else
      begin
        unique case (span_code[c])
          2'b00:   mode = AFE_CM_HALF_SPAN;
          2'b01:   mode = AFE_CM_6V;
          2'b10:   mode = AFE_CM_12V;
          default: mode = AFE_CM_HALF_SPAN;
        endcase
      end
    end
    assign cm_mode[c] = mode;
  end

  // Channel B span decode
  // Codes above 5 give zero span and clear the ok flag
  always_comb
  begin
    span_b    = SPAN_NONE;
    span_b_ok = 1'b1;
    unique case (range_b)
      RANGE_CODE_5V:  span_b = SPAN_5V;
      RANGE_CODE_3V5: span_b = SPAN_3V5;
      RANGE_CODE_2V5: span_b = SPAN_2V5;
      RANGE_CODE_7V:  span_b = SPAN_7V;
      RANGE_CODE_10V: span_b = SPAN_10V;
      RANGE_CODE_12V: span_b = SPAN_12V;
      default:
      begin
        span_b    = SPAN_NONE;
        span_b_ok = 1'b0;
      end
    endcase
  end

  // Decoded configuration toward the analog front end
  always_comb
  begin
    nxt_cfg                  = '0;
    nxt_cfg.chan_b_span      = span_b;
    nxt_cfg.chan_b_span_ok   = span_b_ok;
    nxt_cfg.chan_a_cm        = cm_mode[0];
    nxt_cfg.chan_b_cm        = cm_mode[1];
    nxt_cfg.whole_chip_sleep = reg_q[IDX_CM_AND_PD][POS_WHOLE_CHIP_SLEEP];
  end

  // Decoded configuration register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_ff <= '0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Initialization fields as driven by host software
  always_comb
  begin
    nxt_init              = '0;
    nxt_init.b1_init_a    = reg_q[IDX_B1_INIT_BIT_A][POS_B1_INIT_A];
    nxt_init.b1_init_b    = reg_q[IDX_B1_INIT_BIT_B][POS_B1_INIT_B];
    nxt_init.b2_init_a    = reg_q[IDX_B2_INIT_BIT_A][POS_B2_INIT_A];
    nxt_init.b2_init_b    = reg_q[IDX_B2_INIT_BIT_B][POS_B2_INIT_B];
    nxt_init.b2_init_c    = reg_q[IDX_B2_INIT_BIT_C][POS_B2_INIT_C];
    nxt_init.init_field_f = reg_q[IDX_B2_INIT_FIELD_D][POS_INIT_FIELD_F_LO +: 3];
    nxt_init.init_field_g = reg_q[IDX_B2_INIT_FIELD_E][POS_INIT_FIELD_G_LO +: 2];
  end

  // Initialization field register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_ff <= '0;
    end
    else
    begin
      init_ff <= nxt_init;
    end
  end

endmodule

// ---- design/afe_pkg.sv ----
// Constants, types and register map of the front-end configuration bank.
// Assumes a serial configuration front end on core_clk delivering decoded accesses.
package afe_pkg;

  localparam int unsigned  AFE_ADDR_W    = 8;
  localparam int unsigned  AFE_DATA_W    = 16;
  localparam int unsigned  AFE_REG_COUNT = 10;

  localparam logic [1:0]   AFE_BANK_ONE  = 2'h1;
  localparam logic [1:0]   AFE_BANK_TWO  = 2'h2;

  localparam logic [15:0]  AFE_REG_RESET = 16'h0000;
  localparam logic [15:0]  AFE_RD_NONE   = 16'h0000;

  // Register indices
  localparam int unsigned  IDX_B2_INIT_BIT_A   = 0;
  localparam int unsigned  IDX_B2_INIT_BIT_B   = 1;
  localparam int unsigned  IDX_B2_INIT_BIT_C   = 2;
  localparam int unsigned  IDX_B2_INIT_FIELD_D = 3;
  localparam int unsigned  IDX_B2_INIT_FIELD_E = 4;
  localparam int unsigned  IDX_CHAN_B_RANGE    = 5;
  localparam int unsigned  IDX_CM_AND_PD       = 6;
  localparam int unsigned  IDX_CM_OVERRIDE     = 7;
  localparam int unsigned  IDX_B1_INIT_BIT_A   = 8;
  localparam int unsigned  IDX_B1_INIT_BIT_B   = 9;

  // Register offsets
  localparam logic [7:0]   OFS_BANK2_INIT_BIT_A           = 8'h0A;
  localparam logic [7:0]   OFS_BANK2_INIT_BIT_B           = 8'h12;
  localparam logic [7:0]   OFS_BANK2_INIT_BIT_C           = 8'h13;
  localparam logic [7:0]   OFS_BANK2_INIT_FIELD_D         = 8'h19;
  localparam logic [7:0]   OFS_BANK2_INIT_FIELD_E         = 8'h1F;
  localparam logic [7:0]   OFS_CHANNEL_B_RANGE            = 8'hC3;
  localparam logic [7:0]   OFS_COMMON_MODE_AND_POWER_DOWN = 8'hC4;
  localparam logic [7:0]   OFS_COMMON_MODE_GLOBAL_OVERRIDE = 8'hC5;
  localparam logic [7:0]   OFS_BANK1_INIT_BIT_A           = 8'hF4;
  localparam logic [7:0]   OFS_BANK1_INIT_BIT_B           = 8'hF6;

  localparam logic [7:0]   AFE_REG_OFS  [AFE_REG_COUNT] = '{
    OFS_BANK2_INIT_BIT_A, OFS_BANK2_INIT_BIT_B, OFS_BANK2_INIT_BIT_C,
    OFS_BANK2_INIT_FIELD_D, OFS_BANK2_INIT_FIELD_E, OFS_CHANNEL_B_RANGE,
    OFS_COMMON_MODE_AND_POWER_DOWN, OFS_COMMON_MODE_GLOBAL_OVERRIDE,
    OFS_BANK1_INIT_BIT_A, OFS_BANK1_INIT_BIT_B};
  localparam logic [1:0]   AFE_REG_BANK [AFE_REG_COUNT] = '{
    AFE_BANK_TWO, AFE_BANK_TWO, AFE_BANK_TWO, AFE_BANK_TWO, AFE_BANK_TWO,
    AFE_BANK_ONE, AFE_BANK_ONE, AFE_BANK_ONE, AFE_BANK_ONE, AFE_BANK_ONE};

  // Field positions
  localparam int unsigned  POS_CHAN_B_RANGE_LO   = 4;
  localparam int unsigned  POS_CHAN_B_CM_SPAN_LO = 8;
  localparam int unsigned  POS_CHAN_A_CM_SPAN_LO = 6;
  localparam int unsigned  POS_CHAN_B_CM_CTRL_ON = 3;
  localparam int unsigned  POS_CHAN_A_CM_CTRL_ON = 2;
  localparam int unsigned  POS_WHOLE_CHIP_SLEEP  = 0;
  localparam int unsigned  POS_CM_GLOBAL_OVERRIDE = 4;
  localparam int unsigned  POS_B1_INIT_A         = 1;
  localparam int unsigned  POS_B1_INIT_B         = 1;
  localparam int unsigned  POS_B2_INIT_A         = 14;
  localparam int unsigned  POS_B2_INIT_B         = 6;
  localparam int unsigned  POS_B2_INIT_C         = 15;
  localparam int unsigned  POS_INIT_FIELD_F_LO   = 9;
  localparam int unsigned  POS_INIT_FIELD_G_LO   = 11;

  // Range codes and spans in units of 100 mV
  localparam logic [3:0]   RANGE_CODE_5V   = 4'h0;
  localparam logic [3:0]   RANGE_CODE_3V5  = 4'h1;
  localparam logic [3:0]   RANGE_CODE_2V5  = 4'h2;
  localparam logic [3:0]   RANGE_CODE_7V   = 4'h3;
  localparam logic [3:0]   RANGE_CODE_10V  = 4'h4;
  localparam logic [3:0]   RANGE_CODE_12V  = 4'h5;
  localparam logic [6:0]   SPAN_5V         = 7'h32;
  localparam logic [6:0]   SPAN_3V5        = 7'h23;
  localparam logic [6:0]   SPAN_2V5        = 7'h19;
  localparam logic [6:0]   SPAN_7V         = 7'h46;
  localparam logic [6:0]   SPAN_10V        = 7'h64;
  localparam logic [6:0]   SPAN_12V        = 7'h78;
  localparam logic [6:0]   SPAN_NONE       = 7'h00;

  typedef enum logic [1:0]
  {
    AFE_CM_HALF_SPAN = 2'b00,
    AFE_CM_6V        = 2'b01,
    AFE_CM_12V       = 2'b10
  } afe_cm_e;

  typedef struct packed
  {
    logic [1:0]  bank;
    logic [7:0]  addr;
    logic [15:0] data;
  } afe_req_s;

  typedef struct packed
  {
    logic        b1_init_a;
    logic        b1_init_b;
    logic        b2_init_a;
    logic        b2_init_b;
    logic        b2_init_c;
    logic [2:0]  init_field_f;
    logic [1:0]  init_field_g;
  } afe_init_s;

  typedef struct packed
  {
    logic [6:0]  chan_b_span;
    logic        chan_b_span_ok;
    afe_cm_e     chan_a_cm;
    afe_cm_e     chan_b_cm;
    logic        whole_chip_sleep;
  } afe_cfg_s;

endpackage

// ---- dv/afe_cfg_regs_bench.sv ----
// Self-checking bench for the configuration bank.
// Assumes the host model carries all register traffic.
module afe_cfg_regs_bench
  import afe_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        rst_n;
  afe_req_s    req;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rd_data_ff;
  logic        rd_ack_ff;
  logic        unmapped_ff;
  afe_cfg_s    cfg_ff;
  afe_init_s   init_ff;
  logic [15:0] shadow [AFE_REG_COUNT];
  logic [6:0]  spans [6] = '{SPAN_5V, SPAN_3V5, SPAN_2V5, SPAN_7V, SPAN_10V, SPAN_12V};
  logic [15:0] fmask [AFE_REG_COUNT] = '{16'h4000, 16'h0040, 16'h8000, 16'h0E00, 16'h1800,
    16'h00F0, 16'h03CD, 16'h0010, 16'h0002, 16'h0002};
  logic [31:0] seed = 32'h4AD52F28;
  int          miscompares = 0;
  int          checks_done = 0;
  int          k;
  afe_host_model u_afe_host_model (.core_clk(core_clk), .req(req), .wr_stb(wr_stb), .rd_stb(rd_stb));
  afe_cfg_regs u_afe_cfg_regs (.core_clk(core_clk), .rst_n(rst_n), .req(req), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data_ff(rd_data_ff), .rd_ack_ff(rd_ack_ff), .unmapped_ff(unmapped_ff),
    .cfg_ff(cfg_ff), .init_ff(init_ff));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [1:0] cm_of(input logic ov, input logic en, input logic [1:0] f);
    return !ov ? 2'h2 : (!en || f == 2'h3) ? 2'h0 : f;
  endfunction
  function automatic logic [15:0] span_exp(input int c);
    if (c > 5)
      return 16'h0000;
    return {8'h00, 1'b1, spans[c]};
  endfunction
  function automatic logic is_mapped(input logic [1:0] b, input logic [7:0] a);
    logic f;
    f = 1'b0;
    for (int i = 0; i < AFE_REG_COUNT; i++)
      f = f | (AFE_REG_BANK[i] == b && AFE_REG_OFS[i] == a);
    return f;
  endfunction
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input int i, input logic [15:0] d);
    u_afe_host_model.acc(1'b1, AFE_REG_BANK[i], AFE_REG_OFS[i], d);
    shadow[i] = d;
  endtask
  task automatic rd(input logic [1:0] b, input logic [7:0] a, input logic [15:0] e);
    u_afe_host_model.acc(1'b0, b, a, 16'h0000);
    cmp("rd_data", e, rd_data_ff);
    cmp("rd_ack", 16'h0001, 16'(rd_ack_ff));
    cmp("unmapped", 16'(!is_mapped(b, a)), 16'(unmapped_ff));
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    for (k = 0; k < AFE_REG_COUNT; k++)
    begin
      shadow[k] = 16'h0000;
      rd(AFE_REG_BANK[k], AFE_REG_OFS[k], 16'h0000);
    end
    cmp("cm_reset", 16'h0002, 16'(cfg_ff.chan_a_cm));
    for (k = 0; k < 16; k++)
    begin
      wr(IDX_CHAN_B_RANGE, 16'(k << 4));
      @(negedge core_clk);
      cmp("span", span_exp(k), 16'({cfg_ff.chan_b_span_ok, cfg_ff.chan_b_span}));
    end
    repeat (60)
    begin
      seed = xs(seed);
      wr(IDX_CM_OVERRIDE, seed[15:0] & 16'h0010);
      wr(IDX_CM_AND_PD, seed[31:16] & 16'h03CD);
      @(negedge core_clk);
      cmp("cm_a", 16'(cm_of(seed[4], seed[18], seed[23:22])), 16'(cfg_ff.chan_a_cm));
      cmp("cm_b", 16'(cm_of(seed[4], seed[19], seed[25:24])), 16'(cfg_ff.chan_b_cm));
      cmp("sleep", 16'(seed[16]), 16'(cfg_ff.whole_chip_sleep));
    end
    repeat (60)
    begin
      seed = xs(seed);
      k = seed[3:0] % AFE_REG_COUNT;
      wr(k, seed[31:16] & fmask[k]);
      seed = xs(seed);
      k = seed[3:0] % AFE_REG_COUNT;
      rd(AFE_REG_BANK[k], AFE_REG_OFS[k], shadow[k]);
    end
    u_afe_host_model.acc(1'b1, AFE_BANK_ONE, OFS_BANK2_INIT_BIT_A, 16'hFFFF);
    rd(AFE_BANK_TWO, OFS_BANK2_INIT_BIT_A, shadow[IDX_B2_INIT_BIT_A]);
    rd(AFE_BANK_ONE, OFS_BANK2_INIT_BIT_A, 16'h0000);
    rd(2'h3, OFS_CHANNEL_B_RANGE, 16'h0000);
    rd(2'h0, OFS_CHANNEL_B_RANGE, 16'h0000);
    u_afe_host_model.init_seq(1'b1);
    @(negedge core_clk);
    cmp("init_on", 16'h03EF, 16'(init_ff));
    u_afe_host_model.init_seq(1'b0);
    @(negedge core_clk);
    cmp("init_off", 16'h000F, 16'(init_ff));
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    rd(AFE_BANK_TWO, OFS_BANK2_INIT_FIELD_E, 16'h0000);
    report_and_stop();
  end
endmodule

// ---- dv/afe_cfg_regs_sva.sv ----
// Assertions on the configuration bank ports.
// Assumes one clock domain; bound at the foot.
module afe_cfg_regs_sva
  import afe_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire afe_req_s              req,
  input wire logic                  wr_stb,
  input wire logic                  rd_stb,
  input wire logic [AFE_DATA_W-1:0] rd_data_ff,
  input wire logic                  rd_ack_ff,
  input wire logic                  unmapped_ff,
  input wire afe_cfg_s              cfg_ff,
  input wire afe_init_s             init_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic b1w;
  assign b1w = wr_stb && req.bank == AFE_BANK_ONE;
  property p_ack; rd_ack_ff == $past(rd_stb); endproperty
  a_ack: assert property (p_ack) else $error("read ack timing");
  property p_quiet; !rd_ack_ff |-> rd_data_ff == AFE_RD_NONE; endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside ack");
  property p_bank; (wr_stb || rd_stb) && req.bank inside {2'h0, 2'h3} |=> unmapped_ff && rd_data_ff == 16'h0000;
  endproperty
  a_bank: assert property (p_bank) else $error("bad bank not refused");
  property p_rst; $rose(rst_n) |-> init_ff == '0 && cfg_ff == '0 && rd_data_ff == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("outputs not zero after reset");
  property p_sleep; b1w && req.addr == 8'hC4 |=> ##1 cfg_ff.whole_chip_sleep == $past(req.data[0], 2);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep bit wrong");
  property p_ovr; b1w && req.addr == 8'hC5 && !req.data[4] |=> ##1 cfg_ff.chan_a_cm == AFE_CM_12V
    && cfg_ff.chan_b_cm == AFE_CM_12V; endproperty
  a_ovr: assert property (p_ovr) else $error("override not forcing");
  property p_ok; b1w && req.addr == 8'hC3 |=> ##1 cfg_ff.chan_b_span_ok == ($past(req.data[7:4], 2) <= 4'h5);
  endproperty
  a_ok: assert property (p_ok) else $error("range code check wrong");
  property p_ten; b1w && req.addr == 8'hC3 && req.data[7:4] == 4'h4 |=> ##1 cfg_ff.chan_b_span == SPAN_10V;
  endproperty
  a_ten: assert property (p_ten) else $error("span for code 4 wrong");
endmodule

bind afe_cfg_regs afe_cfg_regs_sva u_afe_cfg_regs_sva (.core_clk(core_clk), .rst_n(rst_n), .req(req),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_ff(rd_data_ff), .rd_ack_ff(rd_ack_ff),
  .unmapped_ff(unmapped_ff), .cfg_ff(cfg_ff), .init_ff(init_ff));

// ---- dv/afe_host_model.sv ----
// Host controller issuing decoded register accesses.
// Assumes requests go out at the falling edge of core_clk.
module afe_host_model
  import afe_pkg::*;
(
  input  wire logic core_clk,
  output afe_req_s  req,
  output logic      wr_stb,
  output logic      rd_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // One access, then release with a changed bus
  task automatic acc(input logic w, input logic [1:0] b, input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    req = '{b, a, d};
    wr_stb = w;
    rd_stb = !w;
    @(negedge core_clk);
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    req = ~req;
  endtask
  // Init phase when v is 1, normal setup when 0; reserved bits stay zero
  task automatic init_seq(input logic v);
    if (v) acc(1'b1, AFE_BANK_ONE, 8'h33, 16'h0030);
    acc(1'b1, AFE_BANK_ONE, OFS_BANK1_INIT_BIT_A, 16'(v) << 1);
    acc(1'b1, AFE_BANK_ONE, OFS_BANK1_INIT_BIT_B, 16'(v) << 1);
    acc(1'b1, AFE_BANK_TWO, OFS_BANK2_INIT_BIT_A, 16'(v) << 14);
    acc(1'b1, AFE_BANK_TWO, OFS_BANK2_INIT_BIT_B, 16'(v) << 6);
    acc(1'b1, AFE_BANK_TWO, OFS_BANK2_INIT_BIT_C, 16'(v) << 15);
    acc(1'b1, AFE_BANK_TWO, OFS_BANK2_INIT_FIELD_D, 16'h0600);
    acc(1'b1, AFE_BANK_TWO, OFS_BANK2_INIT_FIELD_E, 16'h1800);
    if (!v) acc(1'b1, AFE_BANK_ONE, 8'h33, 16'h0000);
    if (!v) acc(1'b1, AFE_BANK_ONE, 8'h37, 16'h0005);
  endtask
endmodule
